// >>> hdl/psm_mux.sv
/*
  Pin function multiplexer: six selection registers, the output function
  mux of every port A and port B pin, and the routing of pins to the
  serial clock, serial data, timer clock, timer capture and interrupt inputs.
  Assumes pin levels arrive asynchronously, peripheral and general I/O
  signals arrive on clk_in, and software keeps the configuration order.
*/
`timescale 1ns/1ps

// Operation
// - Port A pin 3: 00 GPIO/timer clock, 01 timer out, 10 chip select, 11 data out.
// - Port A pin 2: 01 serial clock, 10 data out, else GPIO.
// - Port A pin 1: 01 data in, 10 analogue channel four, else GPIO/interrupt.
// - Port A pin 0: 01 chip select, 10 data in, else GPIO.
// - Port A pin 7: 01 data out, 10 serial clock, else GPIO/interrupt.
// - Port A pin 6: 01 inverted timer, 10 chip select, 11 data out, 00 GPIO.
// - Port A pin 5: 01 timer out, 10 data in, else GPIO/interrupt.
// - Port A pin 4: 01 data out, 10 serial clock, else GPIO/capture.
// - Port B pins 3..1: 01 analogue channel of same number, else GPIO.
// - Port B pin 5: 01 data out, 10 serial clock, else GPIO/capture.
// - Port B pin 4: 01 data in, else GPIO/timer clock.
// - Upper four bits of port B high select read zero, ignore writes.
// - Serial clock input from A2, A7, B5 or A4 by code.
// - Serial data input from A0, A1, A5 or B4 by code.
// - Interrupt, timer clock, capture reach peripheral only when pin is input.
// - Direction bit 1 makes pin a readable input; 0 a driven output.
// - Capture from A4 or B5; timer clock from A3 or B4.
// - Interrupt from A1 for 00/01, A5 for 10, A7 for 11.
module psm_mux
  import psm_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire logic [psm_pkg::PSM_ADDR_W-1:0] reg_addr_in,
  input  wire logic [psm_pkg::PSM_DATA_W-1:0] reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [psm_pkg::PSM_DATA_W-1:0] reg_rdata_out,
  input  wire logic [7:0]                    pa_pin_in,
  output logic      [7:0]                    pa_pin_out,
  output logic      [7:0]                    pa_pin_oe_n_out,
  input  wire logic [5:0]                    pb_pin_in,
  output logic      [5:0]                    pb_pin_out,
  output logic      [5:0]                    pb_pin_oe_n_out,
  input  wire logic [7:0]                    pa_data_in,
  input  wire logic [7:0]                    pa_direction_control_in,
  output logic      [7:0]                    pa_level_out,
  input  wire logic [5:0]                    pb_data_in,
  input  wire logic [5:0]                    pb_direction_control_in,
  output logic      [5:0]                    pb_level_out,
  input  wire logic                          timer_output_in,
  input  wire logic                          timer_output_inverted_in,
  input  wire logic                          spi_chip_select_in,
  input  wire logic                          spi_chip_select_drive_in,
  input  wire logic                          serial_data_out_in,
  input  wire logic                          serial_data_drive_in,
  input  wire logic                          serial_clock_out_in,
  input  wire logic                          serial_clock_drive_in,
  output logic                               serial_clock_to_periph_out,
  output logic                               serial_data_to_periph_out,
  output logic                               timer_clock_input_out,
  output logic                               timer_capture_input_out,
  output logic                               ext_interrupt_out,
  output logic      [3:0]                    analog_channel_enable_out
);
  import psm_pkg::*;

  localparam int NPIN = PSM_PA_PINS + PSM_PB_PINS;

  // Selection registers.
  logic [7:0] pa_sel_lo_q;
  logic [7:0] pa_sel_hi_q;
  logic [7:0] pb_sel_lo_q;
  logic [7:0] pb_sel_hi_q;
  logic [7:0] in_sel_lo_q;
  logic [7:0] in_sel_hi_q;
  logic [7:0] rdata_q;

  // Pin synchronisers; stage one feeds only stage two.
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;

  // Registered pin drive and peripheral-facing outputs.
  logic [NPIN-1:0] pin_val_q;
  logic [NPIN-1:0] pin_oe_n_q;
  logic            sck_q;
  logic            sdi_q;
  logic            tclk_q;
  logic            cap_q;
  logic            int_q;
  logic [3:0]      an_en_q;

  // Flattened views: port A in bits 7:0, port B in bits 13:8.
  wire  [NPIN-1:0]      pin_raw   = {pb_pin_in, pa_pin_in};
  wire  [NPIN-1:0]      gpio_dat  = {pb_data_in, pa_data_in};
  wire  [NPIN-1:0]      gpio_dir  = {pb_direction_control_in, pa_direction_control_in};
  wire  [2*NPIN-1:0]    sel_codes = {pb_sel_hi_q[3:0], pb_sel_lo_q, pa_sel_hi_q, pa_sel_lo_q};
  psm_fn_t              pin_fn [NPIN];
  logic [NPIN-1:0]      pin_val_d;
  logic [NPIN-1:0]      pin_oe_n_d;
  logic [NPIN-1:0]      pin_is_input;

  // Per-pin function decode and drive selection. Pins set to a data-in or
  // analogue function are never driven so the far end owns the wire.
  for (genvar k = 0; k < NPIN; k++) begin : g_pin
    if (k < PSM_PA_PINS) begin : g_pa
      assign pin_fn[k] = psm_pa_fn(k, sel_codes[2*k +: 2]);
    end else begin : g_pb
      assign pin_fn[k] = psm_pb_fn(k - PSM_PA_PINS, sel_codes[2*k +: 2]);
    end
    assign pin_val_d[k] = (pin_fn[k] == PSM_FN_GPIO)    ? gpio_dat[k] :
                          (pin_fn[k] == PSM_FN_TMR)     ? timer_output_in :
                          (pin_fn[k] == PSM_FN_TMR_INV) ? timer_output_inverted_in :
                          (pin_fn[k] == PSM_FN_SCS)     ? spi_chip_select_in :
                          (pin_fn[k] == PSM_FN_SDO)     ? serial_data_out_in :
                          (pin_fn[k] == PSM_FN_SCK)     ? serial_clock_out_in : 1'b0;
    assign pin_oe_n_d[k] = (pin_fn[k] == PSM_FN_GPIO)    ? gpio_dir[k] :
                           (pin_fn[k] == PSM_FN_TMR)     ? 1'b0 :
                           (pin_fn[k] == PSM_FN_TMR_INV) ? 1'b0 :
                           (pin_fn[k] == PSM_FN_SCS)     ? !spi_chip_select_drive_in :
                           (pin_fn[k] == PSM_FN_SDO)     ? !serial_data_drive_in :
                           (pin_fn[k] == PSM_FN_SCK)     ? !serial_clock_drive_in : 1'b1;
    // Timer clock, capture and interrupt inputs only pass while the pin is GPIO and an input.
    assign pin_is_input[k] = (pin_fn[k] == PSM_FN_GPIO) && gpio_dir[k];
  end

  // Input source selection from synchronised pin levels.
  wire [1:0] sck_src  = in_sel_lo_q[PSM_FLD_SCK_SRC  +: PSM_SEL_W];
  wire [1:0] sdi_src  = in_sel_lo_q[PSM_FLD_SDI_SRC  +: PSM_SEL_W];
  wire [1:0] cap_src  = in_sel_lo_q[PSM_FLD_CAP_SRC  +: PSM_SEL_W];
  wire [1:0] tclk_src = in_sel_lo_q[PSM_FLD_TCLK_SRC +: PSM_SEL_W];
  wire [1:0] int_src  = in_sel_hi_q[PSM_FLD_INT_SRC  +: PSM_SEL_W];

  wire sck_d = (sck_src == 2'b00) ? pin_s2_q[2] :
               (sck_src == 2'b01) ? pin_s2_q[7] :
               (sck_src == 2'b10) ? pin_s2_q[13] : pin_s2_q[4];
  wire sdi_d = (sdi_src == 2'b00) ? pin_s2_q[0] :
               (sdi_src == 2'b01) ? pin_s2_q[1] :
               (sdi_src == 2'b10) ? pin_s2_q[5] : pin_s2_q[12];
  wire [3:0] cap_pin  = cap_src[1]  ? 4'hd : 4'h4;
  wire [3:0] tclk_pin = tclk_src[1] ? 4'hc : 4'h3;
  wire [3:0] int_pin  = (!int_src[1]) ? 4'h1 : (!int_src[0]) ? 4'h5 : 4'h7;
  wire cap_d  = pin_s2_q[cap_pin]  && pin_is_input[cap_pin];
  wire tclk_d = pin_s2_q[tclk_pin] && pin_is_input[tclk_pin];
  wire int_d  = pin_s2_q[int_pin]  && pin_is_input[int_pin];

  // Analogue channel enables: channel four on port A pin 1, one to three on port B.
  wire [3:0] an_en_d = {pin_fn[1] == PSM_FN_ANALOG, pin_fn[11] == PSM_FN_ANALOG,
                        pin_fn[10] == PSM_FN_ANALOG, pin_fn[9] == PSM_FN_ANALOG};

  // Register write decode.
  wire wr_pa_lo = reg_wr_in && (reg_addr_in == PSM_OFF_PA_SEL_LO);
  wire wr_pa_hi = reg_wr_in && (reg_addr_in == PSM_OFF_PA_SEL_HI);
  wire wr_pb_lo = reg_wr_in && (reg_addr_in == PSM_OFF_PB_SEL_LO);
  wire wr_pb_hi = reg_wr_in && (reg_addr_in == PSM_OFF_PB_SEL_HI);
  wire wr_in_lo = reg_wr_in && (reg_addr_in == PSM_OFF_IN_SEL_LO);
  wire wr_in_hi = reg_wr_in && (reg_addr_in == PSM_OFF_IN_SEL_HI);

  // Read mux; unmapped indices read zero and data stands for one cycle only.
  wire [7:0] rd_mux = (reg_addr_in == PSM_OFF_PA_SEL_LO) ? pa_sel_lo_q :
                      (reg_addr_in == PSM_OFF_PA_SEL_HI) ? pa_sel_hi_q :
                      (reg_addr_in == PSM_OFF_PB_SEL_LO) ? pb_sel_lo_q :
                      (reg_addr_in == PSM_OFF_PB_SEL_HI) ? pb_sel_hi_q :
                      (reg_addr_in == PSM_OFF_IN_SEL_LO) ? in_sel_lo_q :
                      (reg_addr_in == PSM_OFF_IN_SEL_HI) ? in_sel_hi_q : 8'h00;
  wire [7:0] rdata_d = reg_rd_in ? rd_mux : 8'h00;

  // Selection registers. Masking at write time keeps unimplemented bits at zero.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pa_sel_lo_q <= PSM_RST_SEL;
      pa_sel_hi_q <= PSM_RST_SEL;
      pb_sel_lo_q <= PSM_RST_SEL;
      pb_sel_hi_q <= PSM_RST_SEL;
      in_sel_lo_q <= PSM_RST_SEL;
      in_sel_hi_q <= PSM_RST_SEL;
    end else begin
      if (wr_pa_lo) pa_sel_lo_q <= reg_wdata_in;
      if (wr_pa_hi) pa_sel_hi_q <= reg_wdata_in;
      if (wr_pb_lo) pb_sel_lo_q <= reg_wdata_in;
      if (wr_pb_hi) pb_sel_hi_q <= reg_wdata_in & PSM_MASK_PB_SEL_HI;
      if (wr_in_lo) in_sel_lo_q <= reg_wdata_in;
      if (wr_in_hi) in_sel_hi_q <= reg_wdata_in & PSM_MASK_IN_SEL_HI;
    end
  end

  // Read data register.
  always_ff @(posedge clk_in) begin
    if (reset_in) rdata_q <= 8'h00;
    else          rdata_q <= rdata_d;
  end

  // Two-stage synchroniser on every pin level.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pin drive registers. Reset leaves every pin undriven, as an input.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_val_q  <= '0;
      pin_oe_n_q <= '1;
    end else begin
      pin_val_q  <= pin_val_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // Peripheral-facing inputs and analogue enables.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sck_q   <= 1'b0;
      sdi_q   <= 1'b0;
      tclk_q  <= 1'b0;
      cap_q   <= 1'b0;
      int_q   <= 1'b0;
      an_en_q <= 4'h0;
    end else begin
      sck_q   <= sck_d;
      sdi_q   <= sdi_d;
      tclk_q  <= tclk_d;
      cap_q   <= cap_d;
      int_q   <= int_d;
      an_en_q <= an_en_d;
    end
  end

  assign reg_rdata_out              = rdata_q;
  assign pa_pin_out                 = pin_val_q[7:0];
  assign pa_pin_oe_n_out            = pin_oe_n_q[7:0];
  assign pb_pin_out                 = pin_val_q[13:8];
  assign pb_pin_oe_n_out            = pin_oe_n_q[13:8];
  assign pa_level_out               = pin_s2_q[7:0];
  assign pb_level_out               = pin_s2_q[13:8];
  assign serial_clock_to_periph_out = sck_q;
  assign serial_data_to_periph_out  = sdi_q;
  assign timer_clock_input_out      = tclk_q;
  assign timer_capture_input_out    = cap_q;
  assign ext_interrupt_out          = int_q;
  assign analog_channel_enable_out  = an_en_q;

  // Checks. Outputs follow their cause by one registered cycle.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_pb_hi_write;
    reg_wr_in && (reg_addr_in == PSM_OFF_PB_SEL_HI);
  endsequence
  sequence s_pb_hi_read;
    reg_rd_in && (reg_addr_in == PSM_OFF_PB_SEL_HI);
  endsequence

  AST_PA3_TIMER: assert property ((pa_sel_lo_q[7:6] == 2'b01) |=>
    (pa_pin_out[3] == $past(timer_output_in)) && !pa_pin_oe_n_out[3])
    else $error("Port A pin 3 does not carry the timer output.");
  AST_PA2_SCK: assert property ((pa_sel_lo_q[5:4] == 2'b01) |=>
    (pa_pin_out[2] == $past(serial_clock_out_in)) &&
    (pa_pin_oe_n_out[2] == !$past(serial_clock_drive_in)))
    else $error("Port A pin 2 does not carry the serial clock.");
  AST_PA1_ANALOG: assert property ((pa_sel_lo_q[3:2] == 2'b10) |=>
    analog_channel_enable_out[3] && pa_pin_oe_n_out[1])
    else $error("Port A pin 1 not released to analogue channel four.");
  AST_PA0_SDI_UNDRIVEN: assert property ((pa_sel_lo_q[1:0] == 2'b10) |=>
    pa_pin_oe_n_out[0])
    else $error("Port A pin 0 driven while serial data input.");
  AST_PA6_TMR_INV: assert property ((pa_sel_hi_q[5:4] == 2'b01) |=>
    (pa_pin_out[6] == $past(timer_output_inverted_in)) && !pa_pin_oe_n_out[6])
    else $error("Port A pin 6 does not carry the inverted timer output.");
  AST_PB_HI_READ_ZERO: assert property (s_pb_hi_write ##1 s_pb_hi_read |=>
    (reg_rdata_out[7:4] == 4'h0) && (reg_rdata_out[3:0] == $past(reg_wdata_in[3:0], 2)))
    else $error("Port B high select upper bits not zero or data lost.");
  AST_SCK_ROUTE: assert property ((in_sel_lo_q[7:6] == 2'b10) |=>
    serial_clock_to_periph_out == $past(pin_s2_q[13]))
    else $error("Serial clock input not taken from port B pin 5.");
  AST_SDI_ROUTE: assert property ((in_sel_lo_q[5:4] == 2'b11) |=>
    serial_data_to_periph_out == $past(pin_s2_q[12]))
    else $error("Serial data input not taken from port B pin 4.");
  AST_INT_GATED: assert property ((int_src == 2'b11) && !pa_direction_control_in[7] |=>
    !ext_interrupt_out)
    else $error("Interrupt passed from a pin set as output.");
  AST_GPIO_DIR: assert property ((pa_sel_hi_q[7:6] == 2'b00) |=>
    pa_pin_oe_n_out[7] == $past(pa_direction_control_in[7]))
    else $error("Port A pin 7 enable does not follow direction bit.");
  AST_TCLK_ROUTE: assert property ((tclk_src[1]) && pin_is_input[12] |=>
    timer_clock_input_out == $past(pin_s2_q[12]))
    else $error("Timer clock not taken from port B pin 4.");
  AST_PB0_GPIO: assert property (1'b1 |=>
    pb_pin_oe_n_out[0] == $past(pb_direction_control_in[0]))
    else $error("Port B pin 0 left general I/O.");

endmodule

// >>> hdl/psm_pkg.sv
/*
  Shared definitions for the pin function multiplexer: register indices,
  field geometry, reset values, write masks and the per-pin function tables.
  Assumes a byte-wide register port whose address counts registers, not bytes.
*/
package psm_pkg;

  // Register port geometry.
  localparam int          PSM_ADDR_W = 3;
  localparam int          PSM_DATA_W = 8;
  localparam int          PSM_SEL_W  = 2;

  // Register indices on the register port.
  localparam logic [2:0]  PSM_OFF_PA_SEL_LO = 3'h0;
  localparam logic [2:0]  PSM_OFF_PA_SEL_HI = 3'h1;
  localparam logic [2:0]  PSM_OFF_PB_SEL_LO = 3'h2;
  localparam logic [2:0]  PSM_OFF_PB_SEL_HI = 3'h3;
  localparam logic [2:0]  PSM_OFF_IN_SEL_LO = 3'h4;
  localparam logic [2:0]  PSM_OFF_IN_SEL_HI = 3'h5;

  // Reset values; every pin starts as general I/O.
  localparam logic [7:0]  PSM_RST_SEL = 8'h00;

  // Implemented bits of the two half-populated registers.
  localparam logic [7:0]  PSM_MASK_PB_SEL_HI = 8'h0f;
  localparam logic [7:0]  PSM_MASK_IN_SEL_HI = 8'h0f;

  // Field positions inside the input source registers.
  localparam int          PSM_FLD_SCK_SRC  = 6;
  localparam int          PSM_FLD_SDI_SRC  = 4;
  localparam int          PSM_FLD_CAP_SRC  = 2;
  localparam int          PSM_FLD_TCLK_SRC = 0;
  localparam int          PSM_FLD_INT_SRC  = 2;

  // Pin counts.
  localparam int          PSM_PA_PINS = 8;
  localparam int          PSM_PB_PINS = 6;

  // Function that a pin carries.
  typedef enum logic [2:0] {
    PSM_FN_GPIO,
    PSM_FN_TMR,
    PSM_FN_TMR_INV,
    PSM_FN_SCS,
    PSM_FN_SDO,
    PSM_FN_SCK,
    PSM_FN_SDI,
    PSM_FN_ANALOG
  } psm_fn_t;

  // Port A function table, one case per pin.
  function automatic psm_fn_t psm_pa_fn(input int pin, input logic [1:0] code);
    psm_fn_t fn;
    fn = PSM_FN_GPIO;
    unique case (pin)
      0: fn = (code == 2'b01) ? PSM_FN_SCS : (code == 2'b10) ? PSM_FN_SDI : PSM_FN_GPIO;
      1: fn = (code == 2'b01) ? PSM_FN_SDI : (code == 2'b10) ? PSM_FN_ANALOG : PSM_FN_GPIO;
      2: fn = (code == 2'b01) ? PSM_FN_SCK : (code == 2'b10) ? PSM_FN_SDO : PSM_FN_GPIO;
      3: fn = (code == 2'b01) ? PSM_FN_TMR : (code == 2'b10) ? PSM_FN_SCS :
              (code == 2'b11) ? PSM_FN_SDO : PSM_FN_GPIO;
      4: fn = (code == 2'b01) ? PSM_FN_SDO : (code == 2'b10) ? PSM_FN_SCK : PSM_FN_GPIO;
      5: fn = (code == 2'b01) ? PSM_FN_TMR : (code == 2'b10) ? PSM_FN_SDI : PSM_FN_GPIO;
      6: fn = (code == 2'b01) ? PSM_FN_TMR_INV : (code == 2'b10) ? PSM_FN_SCS :
              (code == 2'b11) ? PSM_FN_SDO : PSM_FN_GPIO;
      default: fn = (code == 2'b01) ? PSM_FN_SDO : (code == 2'b10) ? PSM_FN_SCK : PSM_FN_GPIO;
    endcase
    return fn;
  endfunction

  // Port B function table; pin 0 has no alternate function defined yet.
  function automatic psm_fn_t psm_pb_fn(input int pin, input logic [1:0] code);
    psm_fn_t fn;
    fn = PSM_FN_GPIO;
    unique case (pin)
      0: fn = PSM_FN_GPIO;
      1, 2, 3: fn = (code == 2'b01) ? PSM_FN_ANALOG : PSM_FN_GPIO;
      4: fn = (code == 2'b01) ? PSM_FN_SDI : PSM_FN_GPIO;
      default: fn = (code == 2'b01) ? PSM_FN_SDO : (code == 2'b10) ? PSM_FN_SCK : PSM_FN_GPIO;
    endcase
    return fn;
  endfunction

endpackage

// >>> verification/psm_periph_model.sv
/*
  Behavioural model of the on-chip peripherals behind the pin multiplexer:
  a timer with true and inverted outputs, and a serial unit with chip
  select, data and clock outputs, each with its own drive enable.
  Assumes the bench changes enable_in and value_in just after a rising edge.
*/
`timescale 1ns/1ps
module psm_periph_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       enable_in,
  input  wire logic [3:0] value_in,
  output logic            timer_output_out,
  output logic            timer_output_inverted_out,
  output logic            spi_chip_select_out,
  output logic            spi_chip_select_drive_out,
  output logic            serial_data_out_out,
  output logic            serial_data_drive_out,
  output logic            serial_clock_out_out,
  output logic            serial_clock_drive_out
);
  logic toggle_q;

  // A released serial line changes every cycle, so a mux that passes it while undriven is seen.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
    end
  end

  // The timer always drives; the serial unit drives only while software has it enabled.
  assign timer_output_out          = value_in[0];
  assign timer_output_inverted_out = ~value_in[0];
  assign spi_chip_select_out       = enable_in ? value_in[1] : toggle_q;
  assign serial_data_out_out       = enable_in ? value_in[2] : ~toggle_q;
  assign serial_clock_out_out      = enable_in ? value_in[3] : toggle_q;
  assign spi_chip_select_drive_out = enable_in;
  assign serial_data_drive_out     = enable_in;
  assign serial_clock_drive_out    = enable_in;
endmodule

// >>> verification/shared_pin_function_mux_tb.sv
/*
  Self-checking bench for the pin function multiplexer: register access,
  pin function tables, input routing and reset state, checked through a queue.
  Assumes psm_pkg, psm_mux and psm_periph_model are compiled first.
*/
`timescale 1ns/1ps
module shared_pin_function_mux_tb;
  import psm_pkg::*;
  typedef struct {logic [50:0] exp; logic [50:0] msk;} psm_note_t;
  localparam logic [7:0] WMASK [8] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h00, 8'h00};
  localparam int         SCK_SRC [4] = '{2, 7, 13, 4};
  localparam int         SDI_SRC [4] = '{0, 1, 5, 12};
  localparam int         INT_SRC [4] = '{1, 1, 5, 7};
  string       pa_map [8] = '{"GCDG", "GDAG", "GKOG", "GTCO", "GOKG", "GTDG", "GICO", "GOKG"};
  string       pb_map [6] = '{"GGGG", "GAGG", "GAGG", "GAGG", "GDGG", "GOKG"};
  logic        clk_in, reset_in, reg_wr_in, reg_rd_in, probe, per_en;
  logic        rd_seen = 1'b0;
  logic [2:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, pa_pin_in, pa_pin_out, pa_pin_oe_n_out;
  logic [7:0]  pa_data_in, pa_direction_control_in, pa_level_out;
  logic [5:0]  pb_pin_in, pb_pin_out, pb_pin_oe_n_out, pb_data_in, pb_direction_control_in;
  logic [5:0]  pb_level_out;
  logic [3:0]  per_val, analog_channel_enable_out;
  logic        timer_output_in, timer_output_inverted_in, spi_chip_select_in;
  logic        spi_chip_select_drive_in, serial_data_out_in, serial_data_drive_in;
  logic        serial_clock_out_in, serial_clock_drive_in, serial_clock_to_periph_out;
  logic        serial_data_to_periph_out, timer_clock_input_out, timer_capture_input_out;
  logic        ext_interrupt_out;
  logic [7:0]  sel [8];
  logic [50:0] obs, got;
  psm_note_t   notes [$];
  psm_note_t   cur;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  wire  [13:0] dat = {pb_data_in, pa_data_in};
  wire  [13:0] dir = {pb_direction_control_in, pa_direction_control_in};
  wire  [13:0] pin = {pb_pin_in, pa_pin_in};

  psm_mux u_psm_mux (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .pa_pin_in, .pa_pin_out, .pa_pin_oe_n_out, .pb_pin_in, .pb_pin_out,
    .pb_pin_oe_n_out, .pa_data_in, .pa_direction_control_in, .pa_level_out, .pb_data_in,
    .pb_direction_control_in, .pb_level_out, .timer_output_in, .timer_output_inverted_in,
    .spi_chip_select_in, .spi_chip_select_drive_in, .serial_data_out_in, .serial_data_drive_in,
    .serial_clock_out_in, .serial_clock_drive_in, .serial_clock_to_periph_out,
    .serial_data_to_periph_out, .timer_clock_input_out, .timer_capture_input_out,
    .ext_interrupt_out, .analog_channel_enable_out);

  psm_periph_model u_psm_periph_model (.clk_in, .reset_in, .enable_in(per_en),
    .value_in(per_val), .timer_output_out(timer_output_in),
    .timer_output_inverted_out(timer_output_inverted_in),
    .spi_chip_select_out(spi_chip_select_in), .spi_chip_select_drive_out(spi_chip_select_drive_in),
    .serial_data_out_out(serial_data_out_in), .serial_data_drive_out(serial_data_drive_in),
    .serial_clock_out_out(serial_clock_out_in), .serial_clock_drive_out(serial_clock_drive_in));

  // All outputs except the read data side by side, in the same order as the expected vector.
  assign obs = {analog_channel_enable_out, pa_pin_out, pa_pin_oe_n_out, pb_pin_out,
                pb_pin_oe_n_out, serial_clock_to_periph_out, serial_data_to_periph_out,
                timer_clock_input_out, timer_capture_input_out, ext_interrupt_out,
                pa_level_out, pb_level_out};

  // Free-running 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Function letter of pin i (0..7 port A, 8..13 port B) under the shadow selections.
  function automatic byte fn_of(input int i);
    int         k;
    logic [7:0] s;
    k = (i < 8) ? i : i - 8;
    s = sel[(i < 8 ? 0 : 2) + k / 4];
    return (i < 8) ? pa_map[k][s[k % 4 * 2 +: 2]] : pb_map[k][s[k % 4 * 2 +: 2]];
  endfunction

  // Timer clock, capture and interrupt reach their peripheral only from a GPIO-coded input pin.
  function automatic logic gp(input int k);
    return pin[k] & (fn_of(k) == "G") & dir[k];
  endfunction

  function automatic psm_note_t expect_pins();
    psm_note_t   n;
    logic [13:0] po, pe, pm;
    logic [4:0]  rt;
    logic [3:0]  an;
    byte         c;
    for (int i = 0; i < 14; i++) begin
      c = fn_of(i);
      case (c)
        "T": {po[i], pe[i]} = {per_val[0], 1'b0};
        "I": {po[i], pe[i]} = {~per_val[0], 1'b0};
        "C": {po[i], pe[i]} = {per_val[1], ~per_en};
        "O": {po[i], pe[i]} = {per_val[2], ~per_en};
        "K": {po[i], pe[i]} = {per_val[3], ~per_en};
        "G": {po[i], pe[i]} = {dat[i], dir[i]};
        default: {po[i], pe[i]} = 2'b01;
      endcase
      pm[i] = ~pe[i] | (c == "D") | (c == "A");
    end
    an = {fn_of(1) == "A", fn_of(11) == "A", fn_of(10) == "A", fn_of(9) == "A"};
    rt = {pin[SCK_SRC[sel[4][7:6]]], pin[SDI_SRC[sel[4][5:4]]], gp(sel[4][1] ? 12 : 3),
          gp(sel[4][3] ? 13 : 4), gp(INT_SRC[sel[5][3:2]])};
    n.exp = {an, po[7:0], pe[7:0], po[13:8], pe[13:8], rt, pin[7:0], pin[13:8]};
    n.msk = {4'hf, pm[7:0], 8'hff, pm[13:8], 6'h3f, 5'h1f, 14'h3fff};
    return n;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    sel[a] = d & WMASK[a];
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [2:0] a);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    notes.push_back('{51'(sel[a]), 51'hff});
    @(posedge clk_in);
  endtask

  task automatic idle();
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic probe_pins();
    notes.push_back(expect_pins());
    probe <= 1'b1;
    @(posedge clk_in);
    probe <= 1'b0;
    @(posedge clk_in);
  endtask

  // Reset the design, clear the shadow registers, then read everything back.
  task automatic reset_and_read();
    reset_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int a = 0; a < 8; a++) sel[a] = 8'h00;
    for (int a = 0; a < 8; a++) rd(3'(a));
    idle();
    repeat (4) @(posedge clk_in);
    probe_pins();
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Takes the oldest note whenever read data or a probed output snapshot is due.
  always @(posedge clk_in) begin
    if (rd_seen || probe) begin
      got = rd_seen ? {43'h0, reg_rdata_out} : obs;
      if (notes.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t result with no expectation", $time);
      end else begin
        cur = notes.pop_front();
        num_checks++;
        if ((got & cur.msk) !== (cur.exp & cur.msk)) begin
          num_errors++;
          $display("[ERR] %0t got %h exp %h", $time, got & cur.msk, cur.exp & cur.msk);
        end
      end
    end
    rd_seen <= reg_rd_in;
  end

  // A hang costs at most a few thousand cycles; the full run needs about seven hundred.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("[ERR] %0t run did not finish", $time);
      stop_test();
    end
  end

  initial begin
    {reg_wr_in, reg_rd_in, probe, per_en, per_val} = 8'h00;
    {reg_addr_in, reg_wdata_in} = 11'h000;
    {pa_pin_in, pa_data_in, pa_direction_control_in} = 24'h000000;
    {pb_pin_in, pb_data_in, pb_direction_control_in} = 18'h00000;
    reset_in = 1'b1;
    void'($urandom(84955));
    reset_and_read();
    $display("test reset_values done");
    for (int a = 0; a < 8; a++) wr(3'(a), 8'hff);
    for (int a = 0; a < 8; a++) rd(3'(a));
    for (int a = 0; a < 8; a++) begin
      wr(3'(a), 8'($urandom));
      rd(3'(a));
    end
    idle();
    $display("test reg_access done");
    // The first four passes set every field to one code; the rest are random mixes.
    for (int it = 0; it < 44; it++) begin
      per_en <= 1'b0;
      {pa_pin_in, pa_data_in, pa_direction_control_in} <= 24'($urandom);
      {pb_pin_in, pb_data_in, pb_direction_control_in} <= 18'($urandom);
      per_val <= 4'($urandom);
      for (int a = 0; a < 6; a++) wr(3'(a), (it < 4) ? 8'(8'h55 * it) : 8'($urandom));
      idle();
      per_en <= 1'($urandom);
      repeat (5) @(posedge clk_in);
      probe_pins();
    end
    $display("test pin_functions done");
    // Data-in on port A pin 0 with its matching source, interrupt from a GPIO-coded pin 7.
    per_en <= 1'b0;
    pa_direction_control_in[7] <= 1'b1;
    wr(3'h0, 8'h02);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h5, 8'h0c);
    idle();
    repeat (5) @(posedge clk_in);
    probe_pins();
    $display("test shared_inputs done");
    reset_and_read();
    $display("test second_reset done");
    repeat (3) @(posedge clk_in);
    if (notes.size() != 0) begin
      num_errors++;
      $display("[ERR] %0t expected results never appeared", $time);
    end
    stop_test();
  end
endmodule
